// ===== core/sccp_core.sv
// Purpose: Command word and command scheduler of the communications processor
// Assumes: Host writes the command word through a direct 8-bit port
// Notes:   Soft reset drives o_cp_reset_n; interrupt pending bits lie outside it
`timescale 1ns/10ps

module sccp_core
   import sccp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_reset_n,
   input  wire logic              i_cmd_wr,
   input  wire logic [7:0]        i_cmd_wdata,
   output logic [7:0]             o_cmd_rdata,
   input  wire logic              i_refresh_req,
   input  wire logic              i_refresh_en,
   input  wire logic [2:0]        i_scc_req,
   input  wire sccp_pkg::sccp_proto_t i_scc_proto [3],
   input  wire logic [2:0]        i_scc_msgp,
   output logic                   o_grant_refresh,
   output logic [2:0]             o_grant_scc,
   output sccp_pkg::sccp_action_t o_action,
   output logic                   o_abort_bit,
   output logic                   o_cp_reset_n,
   output logic [8:0]             o_latency_budget
);
   import sccp_pkg::*;

   sccp_cmd_t    cmd_r;
   sccp_cmd_t    cmd_nxt;
   sccp_action_t action_r;
   sccp_action_t action_nxt;
   logic         abort_r;
   logic [2:0]   srst_cnt_r;
   logic [8:0]   budget_r;
   logic         running_r;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FINISH} sccp_state_t;
   sccp_state_t  state_r;
   sccp_state_t  state_nxt;

   wire logic       srst_busy = (srst_cnt_r != 3'h0);
   wire logic       busy;
   wire logic       done;
   wire logic       start;
   wire logic [5:0] exec_clks;
   wire logic       hunt_cmd;
   wire logic       chan_ok;
   wire logic [7:0] proto_clks;
   wire logic [8:0] budget_nxt;
   wire logic       scc_grant_ok;
   wire logic       tmr_load;
   wire logic [5:0] tmr_count;
   wire logic       any_bisync;
   wire logic       any_hdlc;
   wire logic       any_uart;
   wire logic       any_msgp;
   wire logic       op_is_0;
   wire logic       op_is_1;
   wire logic       op_is_2;
   wire logic       op_is_3;
   wire logic       tgt_bisync;

   // Host write and completion clear; a taken write wins over the clear, and one while pending needs the soft reset bit
   always_comb begin
      cmd_nxt = cmd_r;
      if (state_r == ST_FINISH) begin
         cmd_nxt.command_pending = 1'b0;
      end
      if (srst_cnt_r == 3'h1) begin
         cmd_nxt = sccp_cmd_t'(CMD_RESET);
      end
      if (i_cmd_wr && (!cmd_r.command_pending || i_cmd_wdata[SRST_BIT])) begin
         cmd_nxt = sccp_cmd_t'(i_cmd_wdata);
      end
   end

   // Command scheduler: refresh first, then commands, then controllers
   assign o_grant_refresh = i_refresh_req && !srst_busy;
   assign start = (state_r == ST_IDLE) && cmd_r.command_pending && !cmd_r.soft_reset_request
                  && !i_refresh_req && !srst_busy;
   assign scc_grant_ok   = !i_refresh_req && !start && !running_r && !srst_busy;
   assign o_grant_scc[0] = i_scc_req[0] && scc_grant_ok;
   assign o_grant_scc[1] = i_scc_req[1] && !i_scc_req[0] && scc_grant_ok;
   assign o_grant_scc[2] = i_scc_req[2] && !(|i_scc_req[1:0]) && scc_grant_ok;

   // Execution time by command
   assign hunt_cmd  = !cmd_r.mgmt_bus_command_select && (cmd_r.opcode == 2'b10);
   assign exec_clks = hunt_cmd ? 6'(HUNT_CLKS) : 6'(OTHER_CLKS);
   assign chan_ok   = (cmd_r.target_channel != 2'b11);

   // Soft reset empties the timer so a stale count cannot block the controllers
   assign tmr_load  = start || srst_busy;
   assign tmr_count = srst_busy ? 6'h00 : exec_clks;

   sccp_timer u_timer (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_load    (tmr_load),
      .i_count   (tmr_count),
      .o_busy    (busy),
      .o_done    (done)
   );

   // Command sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:   if (start) state_nxt = ST_EXEC;
         ST_EXEC:   if (done) state_nxt = ST_FINISH;
         ST_FINISH: state_nxt = ST_IDLE;
         default:   state_nxt = ST_IDLE;
      endcase
      if (srst_busy) begin
         state_nxt = ST_IDLE;
      end
   end

   // Opcode and target decode for the completion strobes
   assign op_is_0    = (cmd_r.opcode == 2'b00);
   assign op_is_1    = (cmd_r.opcode == 2'b01);
   assign op_is_2    = (cmd_r.opcode == 2'b10);
   assign op_is_3    = (cmd_r.opcode == 2'b11);
   assign tgt_bisync = (i_scc_proto[cmd_r.target_channel] == PROTO_BISYNC);

   // Action decode at completion
   always_comb begin
      action_nxt = '0;
      if (state_r == ST_FINISH) begin
         if (cmd_r.mgmt_bus_command_select) begin
            action_nxt.abort_request = op_is_0;
            action_nxt.timeout_cmd   = op_is_1;
         end else if (chan_ok) begin
            action_nxt.stop_tx[cmd_r.target_channel]    = op_is_0;
            action_nxt.restart_tx[cmd_r.target_channel] = op_is_1;
            action_nxt.enter_hunt[cmd_r.target_channel] = op_is_2;
            action_nxt.reset_bcs[cmd_r.target_channel]  = op_is_3 && tgt_bisync;
         end
      end
   end

   // Which protocols run on any controller
   assign any_bisync = (i_scc_proto[0] == PROTO_BISYNC) || (i_scc_proto[1] == PROTO_BISYNC)
                       || (i_scc_proto[2] == PROTO_BISYNC);
   assign any_hdlc   = (i_scc_proto[0] == PROTO_HDLC) || (i_scc_proto[1] == PROTO_HDLC)
                       || (i_scc_proto[2] == PROTO_HDLC);
   assign any_uart   = (i_scc_proto[0] == PROTO_UART) || (i_scc_proto[1] == PROTO_UART)
                       || (i_scc_proto[2] == PROTO_UART);
   assign any_msgp   = |i_scc_msgp;

   // Latency budget: execution, refresh and largest protocol term
   assign proto_clks = any_bisync ? 8'(BISYNC_CLKS) :
                       any_hdlc   ? 8'(HDLC_CLKS)   :
                       any_uart   ? 8'(UART_CLKS)   :
                       any_msgp   ? 8'(MSGP_CLKS)   : 8'h00;
   assign budget_nxt = 9'(exec_clks) + (i_refresh_en ? 9'(REFRESH_CLKS) : 9'h000)
                       + 9'(proto_clks);

   // Command word register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_r <= sccp_cmd_t'(CMD_RESET);
      end else begin
         cmd_r <= cmd_nxt;
      end
   end

   // Sequencer state and the flag that holds off controller grants
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r   <= ST_IDLE;
         running_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         running_r <= busy || start;
      end
   end

   // Completion strobes; the abort bit follows the abort request
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         action_r <= '0;
         abort_r  <= 1'b0;
      end else begin
         action_r <= action_nxt;
         abort_r  <= action_nxt.abort_request;
      end
   end

   // Latency budget register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         budget_r <= 9'h000;
      end else begin
         budget_r <= budget_nxt;
      end
   end

   // Soft reset counter; interrupt pending bits live outside and are never touched
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         srst_cnt_r <= 3'h0;
      end else if (cmd_r.soft_reset_request && !srst_busy) begin
         srst_cnt_r <= 3'(SRST_CLKS);
      end else if (srst_busy) begin
         srst_cnt_r <= srst_cnt_r - 3'h1;
      end
   end

   // Outputs
   assign o_cmd_rdata      = cmd_r;
   assign o_action         = action_r;
   assign o_abort_bit      = abort_r;
   assign o_cp_reset_n     = !srst_busy;
   assign o_latency_budget = budget_r;
endmodule

// ===== core/sccp_pkg.sv
// Purpose: Shared constants and types for the serial channel command port
// Assumes: 200 MHz system clock, command word reached through a direct 8-bit port
// Notes:   Protocol budget terms are in clocks of the processor core
package sccp_pkg;

   // Command word bit positions
   localparam int CMD_PEND_BIT  = 0;
   localparam int CHAN_LSB      = 1;
   localparam int RSVD_BIT      = 3;
   localparam int OPC_LSB       = 4;
   localparam int MGMT_BIT      = 6;
   localparam int SRST_BIT      = 7;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // Execution times in clocks
   localparam int HUNT_CLKS     = 41;
   localparam int OTHER_CLKS    = 19;
   localparam int REFRESH_CLKS  = 25;
   localparam int BISYNC_CLKS   = 205;
   localparam int HDLC_CLKS     = 165;
   localparam int UART_CLKS     = 150;
   localparam int MSGP_CLKS     = 140;

   // Soft reset pulse length in clocks
   localparam int SRST_CLKS     = 4;

   typedef enum logic [1:0] {
      PROTO_NONE, PROTO_UART, PROTO_HDLC, PROTO_BISYNC
   } sccp_proto_t;

   typedef struct packed {
      logic       soft_reset_request;
      logic       mgmt_bus_command_select;
      logic [1:0] opcode;
      logic       reserved;
      logic [1:0] target_channel;
      logic       command_pending;
   } sccp_cmd_t;

   // Decoded command strobes, one cycle each
   typedef struct packed {
      logic [2:0] stop_tx;
      logic [2:0] restart_tx;
      logic [2:0] enter_hunt;
      logic [2:0] reset_bcs;
      logic       abort_request;
      logic       timeout_cmd;
   } sccp_action_t;

endpackage

// ===== core/sccp_timer.sv
// Purpose: Down counter that times one command execution
// Assumes: Load has priority over counting
// Notes:   Done pulses one cycle when the count reaches one
`timescale 1ns/10ps
module sccp_timer (
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_load,
   input  wire logic [5:0] i_count,
   output logic            o_busy,
   output logic            o_done
);
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;

   // Next count and status
   assign cnt_nxt = i_load ? i_count : (cnt_r != 6'h0 ? cnt_r - 6'h1 : cnt_r);
   assign o_busy  = (cnt_r != 6'h0);
   assign o_done  = (cnt_r == 6'h1);

   // Count register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_r <= 6'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ===== tb/sccp_core_bench.sv
// Purpose: Self-checking bench for the command port core
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Table rows cover every opcode, mode and channel code
`timescale 1ns/10ps
module sccp_core_bench;
   import sccp_pkg::*;
   logic i_clk = 0, i_reset_n = 0, i_cmd_wr = 0, i_refresh_req = 0, i_refresh_en = 1;
   logic [7:0] i_cmd_wdata = '0, o_cmd_rdata;
   logic [2:0] i_scc_req = '0, i_scc_msgp = '0, o_grant_scc;
   sccp_proto_t i_scc_proto [3] = '{PROTO_BISYNC, PROTO_UART, PROTO_HDLC};
   logic o_grant_refresh, o_abort_bit, o_cp_reset_n;
   sccp_action_t o_action;
   logic [8:0] o_latency_budget;
   logic [15:0] n, low;
   logic [13:0] acc;
   logic ab;
   int error_cnt = 0, num_checks = 0;
   localparam logic [7:0] WD [10] = '{8'h01, 8'h13, 8'h25, 8'h31, 8'h33, 8'h45, 8'h55,
                                       8'h65, 8'h75, 8'h07};
   localparam logic [13:0] EA [10] = '{14'h0800, 14'h0200, 14'h0080, 14'h0004, 14'h0000,
                                        14'h0002, 14'h0001, 14'h0000, 14'h0000, 14'h0000};
   sccp_core DUT (
      .i_clk            (i_clk),
      .i_reset_n        (i_reset_n),
      .i_cmd_wr         (i_cmd_wr),
      .i_cmd_wdata      (i_cmd_wdata),
      .o_cmd_rdata      (o_cmd_rdata),
      .i_refresh_req    (i_refresh_req),
      .i_refresh_en     (i_refresh_en),
      .i_scc_req        (i_scc_req),
      .i_scc_proto      (i_scc_proto),
      .i_scc_msgp       (i_scc_msgp),
      .o_grant_refresh  (o_grant_refresh),
      .o_grant_scc      (o_grant_scc),
      .o_action         (o_action),
      .o_abort_bit      (o_abort_bit),
      .o_cp_reset_n     (o_cp_reset_n),
      .o_latency_budget (o_latency_budget)
   );
   always #2.5 i_clk = ~i_clk;
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Wait for pending to clear, gathering action pulses
   task automatic wait_done();
      acc = '0;
      ab = 1'b0;
      n = '0;
      do begin
         @(posedge i_clk);
         #1 n++;
         acc |= o_action;
         ab |= o_abort_bit;
      end while (o_cmd_rdata[0] !== 1'b0 && n < 80);
   endtask
   task automatic put_cmd(input logic [7:0] wd);
      i_cmd_wr = 1'b1;
      i_cmd_wdata = wd;
      @(posedge i_clk);
      #1 i_cmd_wr = 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      chk("rdata", 16'h0000, o_cmd_rdata);
      chk("cp_reset_n", 16'h0001, o_cp_reset_n);
      for (int i = 0; i < 10; i++) begin
         put_cmd(WD[i]);
         wait_done();
         chk("action", EA[i], acc);
         chk("abort_bit", 16'(EA[i][1]), 16'(ab));
         chk("exec_time", 16'h0001, n <= ((EA[i] == 14'h0080) ? 45 : 23));
      end
      // Refused second write, blocked grants and budget during a hunt
      i_cmd_wr = 1'b1;
      i_cmd_wdata = 8'h25;
      @(posedge i_clk);
      #1 i_cmd_wdata = 8'h01;
      @(posedge i_clk);
      #1 i_cmd_wr = 1'b0;
      i_scc_req = 3'h7;
      @(posedge i_clk);
      #1 chk("held", 16'h0025, o_cmd_rdata);
      chk("budget", 16'(HUNT_CLKS + REFRESH_CLKS + BISYNC_CLKS), o_latency_budget);
      chk("scc_blocked", 16'h0000, o_grant_scc);
      wait_done();
      chk("hunt_only", 16'h0080, acc);
      chk("scc_after", 16'h0001, o_grant_scc != 3'h0);
      // Refresh held at the write delays the command start
      i_refresh_req = 1'b1;
      put_cmd(8'h01);
      chk("grant_refresh", 16'h0001, o_grant_refresh);
      repeat (9) @(posedge i_clk);
      #1 i_refresh_req = 1'b0;
      wait_done();
      chk("refresh_first", 16'h0001, n > 18);
      // Soft reset while a command is pending
      i_cmd_wr = 1'b1;
      i_cmd_wdata = 8'h25;
      @(posedge i_clk);
      #1 i_cmd_wdata = 8'h81;
      @(posedge i_clk);
      #1 i_cmd_wr = 1'b0;
      low = '0;
      repeat (12) begin
         @(posedge i_clk);
         #1 low = low + 16'(!o_cp_reset_n);
      end
      chk("srst_len", 16'(SRST_CLKS), low);
      chk("srst_word", 16'h0000, o_cmd_rdata);
      print_verdict();
   end
endmodule

// ===== tb/sccp_core_properties.sv
// Purpose: Concurrent checks on the command word and scheduler ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Cycle bounds follow the hand-over timing of the core
`timescale 1ns/10ps
module sccp_core_properties
   import sccp_pkg::*;
(
   input wire logic                   i_clk,
   input wire logic                   i_reset_n,
   input wire logic                   i_cmd_wr,
   input wire logic [7:0]             i_cmd_wdata,
   input wire logic [7:0]             o_cmd_rdata,
   input wire logic                   i_refresh_req,
   input wire logic                   i_refresh_en,
   input wire logic                   o_grant_refresh,
   input wire logic [2:0]             o_grant_scc,
   input wire sccp_pkg::sccp_action_t o_action,
   input wire logic                   o_abort_bit,
   input wire logic                   o_cp_reset_n
);
   import sccp_pkg::*;
   // All checks share the core clock and reset
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   property p_take; i_cmd_wr && !o_cmd_rdata[0] && i_cmd_wdata[0] && !i_cmd_wdata[7]
      |=> o_cmd_rdata == $past(i_cmd_wdata); endproperty
   a_take: assert property (p_take) else $error("command word not taken");
   property p_hold; o_cmd_rdata[0] && !(i_cmd_wr && i_cmd_wdata[7])
      |=> o_cmd_rdata[7:1] == $past(o_cmd_rdata[7:1]) || o_cmd_rdata == 8'h00; endproperty
   a_hold: assert property (p_hold) else $error("command fields moved");
   property p_done; $rose(o_cmd_rdata[0]) && !o_cmd_rdata[7] |-> ##[1:60] !o_cmd_rdata[0];
   endproperty
   a_done: assert property (p_done) else $error("pending never cleared");
   property p_act; o_action != '0 |-> $fell(o_cmd_rdata[0]); endproperty
   a_act: assert property (p_act) else $error("action apart from completion");
   property p_abort; o_abort_bit == o_action.abort_request; endproperty
   a_abort: assert property (p_abort) else $error("abort bit mismatch");
   property p_refr; i_refresh_req && i_refresh_en && o_cp_reset_n
      |-> o_grant_refresh && o_grant_scc == 3'h0;
   endproperty
   a_refr: assert property (p_refr) else $error("refresh not first");
   property p_srst; i_cmd_wr && i_cmd_wdata[7] |-> ##[1:3] !o_cp_reset_n; endproperty
   a_srst: assert property (p_srst) else $error("soft reset ignored");
   property p_slen; $fell(o_cp_reset_n) |-> !o_cp_reset_n [*4] ##1 o_cp_reset_n; endproperty
   a_slen: assert property (p_slen) else $error("soft reset length");
   property p_sclr; $rose(o_cp_reset_n) |-> ##[0:1] o_cmd_rdata == 8'h00; endproperty
   a_sclr: assert property (p_sclr) else $error("word not cleared");
   c_hunt: cover property (o_action.enter_hunt != 3'h0);
   c_abort: cover property (o_abort_bit);
   c_srst: cover property ($fell(o_cp_reset_n));
endmodule
bind sccp_core sccp_core_properties u_props (
   .i_clk           (i_clk),
   .i_reset_n       (i_reset_n),
   .i_cmd_wr        (i_cmd_wr),
   .i_cmd_wdata     (i_cmd_wdata),
   .o_cmd_rdata     (o_cmd_rdata),
   .i_refresh_req   (i_refresh_req),
   .i_refresh_en    (i_refresh_en),
   .o_grant_refresh (o_grant_refresh),
   .o_grant_scc     (o_grant_scc),
   .o_action        (o_action),
   .o_abort_bit     (o_abort_bit),
   .o_cp_reset_n    (o_cp_reset_n)
);
